/* design/cmd_delay_line.v */
`timescale 1ns/1ps
`default_nettype none
// delays a command word by delay_i + 1 clocks (0 = output register only, one clock)
module cmd_delay_line #(
   parameter WIDTH = 27,
   parameter DEPTH = 8
)(
   input  wire             ref_clk_i,
   input  wire             reset_n_i,
   input  wire [3:0]       delay_i,
   input  wire [WIDTH-1:0] data_i,
   output reg  [WIDTH-1:0] data_o
);
   reg [WIDTH-1:0] stage_r [1:DEPTH];
   genvar g;
   generate
      for (g = 1; g <= DEPTH; g = g + 1)
      begin : g_stage
         if (g == 1)
         begin : g_first
            always @(posedge ref_clk_i or negedge reset_n_i)
            begin
               if (!reset_n_i)
                  stage_r[g] <= {WIDTH{1'b0}};
               else
                  stage_r[g] <= data_i;
            end
         end
         else
         begin : g_next
            always @(posedge ref_clk_i or negedge reset_n_i)
            begin
               if (!reset_n_i)
                  stage_r[g] <= {WIDTH{1'b0}};
               else
                  stage_r[g] <= stage_r[g-1];
            end
         end
      end
   endgenerate
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         data_o <= {WIDTH{1'b0}};
      else if (delay_i == 4'h0)
         data_o <= data_i;
      else
         data_o <= stage_r[delay_i];
   end
endmodule
`default_nettype wire

/* design/mode_feature_regs.vh */
`ifndef MODE_FEATURE_REGS_VH
`define MODE_FEATURE_REGS_VH
// mode register select codes
`define MR_SEL_HI         20
`define MR_SEL_LO         18
`define MR_SEL_FOUR       3'h4
`define MR_SEL_FIVE       3'h5
// mode_reg_four fields
`define MR4_MAXPWR        1
`define MR4_TCR_RANGE     2
`define MR4_TCR_EN        3
`define MR4_TMP_REPAIR    5
`define MR4_CAL_HI        8
`define MR4_CAL_LO        6
`define MR4_RD_TRAIN      10
`define MR4_RD_PRE        11
`define MR4_WR_PRE        12
`define MR4_PERM_REPAIR   13
// mode_reg_five fields
`define MR5_PAR_LAT_HI    2
`define MR5_PAR_LAT_LO    0
`define MR5_CRC_ERR       3
`define MR5_PAR_ERR       4
`define MR5_ODT_BUF_OFF   5
`define MR5_PARK_HI       8
`define MR5_PARK_LO       6
`define MR5_PERSIST       9
`define MR5_WR_MASK       10
`define MR5_WR_INV        11
`define MR5_RD_INV        12
// reset values
`define MR4_RESET         22'h000000
`define MR5_RESET         22'h000000
// multipurpose readout page 2 location 0 bits
`define MPR_PERM_BIT      7
`define MPR_TMP_BIT       6
// longest command/address latency in clocks
`define CAL_MAX           8
`endif

/* design/sdram_mode_feature_regs.v */
// Operation
// - readout page 2 location 0 bit 7 reports permanent repair support
// - permanent repair replaces one row per bank group; kept until reset
// - readout page 2 location 0 bit 6 reports temporary repair support
// - temporary repair one row per group; discarded on reset or power-down
// - read preamble training drives a one or two clock training pattern
// - temperature refresh may skip refreshes; normal 85C, extended 95C range
// - command captured the programmed clocks after chip select low
// - max power saving ignores all but exit; reset still honoured
// - fifth register written by set command with select field 101
// - bit 12 read inversion, bit 11 write inversion, bit 10 write mask
// - bit 9 selects persistent parity-error mode
// - bits 8:6 parked termination: off, then divisors 4,2,6,1,5,3,7
// - bit 5 set disables termination input buffer during power-down
// - bit 4 parity error status, bit 3 write checksum error status
// - bits 2:0 parity latency: off, 4, 5, 6, 8 clocks; rest reserved
// - error status bits stay set until cleared by a set command
// - parity checking stops while error set, unless persistent mode
// - buffer off in power-down: ignore termination input, no nominal term
// - fourth register bits 8:6 give latency off, 3, 4, 5, 6, 8 clocks
`include "mode_feature_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_feature_regs #(
   parameter PERM_REPAIR_SUPPORTED = 1'b1,
   parameter TMP_REPAIR_SUPPORTED  = 1'b1
)(
   input  wire        ref_clk_i,
   input  wire        reset_n_i,
   input  wire        cs_n_i,
   input  wire        act_n_i,
   input  wire        ras_n_i,
   input  wire        cas_n_i,
   input  wire        we_n_i,
   input  wire [1:0]  bank_group_i,
   input  wire [1:0]  bank_i,
   input  wire [17:0] addr_i,
   input  wire        par_err_event_i,
   input  wire        crc_err_event_i,
   input  wire        power_down_i,
   input  wire        termination_control_i,
   input  wire        max_power_exit_i,
   output reg  [7:0]  multipurpose_readout_o,
   output reg  [21:0] mode_reg_five_o,
   output reg  [21:0] mode_reg_four_o,
   output reg         rd_bus_inversion_o,
   output reg         wr_bus_inversion_o,
   output reg         write_byte_mask_o,
   output reg  [3:0]  parity_latency_o,
   output reg  [3:0]  parked_termination_o,
   output reg         nominal_termination_o,
   output reg         parity_check_en_o,
   output reg  [1:0]  read_preamble_len_o,
   output reg  [1:0]  write_preamble_len_o,
   output reg  [1:0]  preamble_train_len_o,
   output reg         temp_controlled_refresh_o,
   output reg  [6:0]  refresh_limit_c_o,
   output reg         max_power_save_o,
   output reg  [3:0]  cal_clocks_o,
   output reg         cmd_valid_o,
   output reg  [26:0] cmd_word_o,
   output reg  [3:0]  perm_repair_used_o,
   output reg  [3:0]  tmp_repair_used_o
);
   // ------------------------------------------------------------------
   // command/address latency
   // ------------------------------------------------------------------
   wire [26:0] raw_cmd;
   wire [26:0] dly_cmd;
   reg  [3:0]  cal_r;
   reg  [3:0]  cal_nxt;
   assign raw_cmd = {~cs_n_i, act_n_i, ras_n_i, cas_n_i, we_n_i, bank_group_i, bank_i, addr_i};
   always @*
   begin
      case (mode_reg_four_o[`MR4_CAL_HI:`MR4_CAL_LO])
         3'h1: cal_nxt = 4'h3;
         3'h2: cal_nxt = 4'h4;
         3'h3: cal_nxt = 4'h5;
         3'h4: cal_nxt = 4'h6;
         3'h5: cal_nxt = 4'h8;
         default: cal_nxt = 4'h0;
      endcase
   end
   // delay equals latency; the output register lines it up with raw_q_r
   cmd_delay_line #(
      .WIDTH (27),
      .DEPTH (`CAL_MAX)
   ) u_cal (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .delay_i   (cal_r),
      .data_i    (raw_cmd),
      .data_o    (dly_cmd)
   );
   // with latency off, the registered raw command is used directly
   reg  [26:0] raw_q_r;
   wire [26:0] cmd;
   // chip select from latency clocks ago, command/address sampled now
   assign cmd = (cal_r == 4'h0) ? raw_q_r : {dly_cmd[26], raw_q_r[25:0]};
   wire cmd_sel;
   wire is_mrs;
   wire [21:0] mr_val;
   // controller-held strobes low during set command
   assign is_mrs  = cmd[26] & cmd[25] & ~cmd[24] & ~cmd[23] & ~cmd[22];
   assign mr_val  = {cmd[21:18], cmd[17:0]};
   assign cmd_sel = is_mrs & ~max_power_save_o;
   wire wr_five = cmd_sel & (mr_val[`MR_SEL_HI:`MR_SEL_LO] == `MR_SEL_FIVE);
   wire wr_four = cmd_sel & (mr_val[`MR_SEL_HI:`MR_SEL_LO] == `MR_SEL_FOUR);
   // ------------------------------------------------------------------
   // fifth and fourth mode registers
   // ------------------------------------------------------------------
   reg [21:0] mr5_r;
   reg [21:0] mr4_r;
   reg        par_err_r;
   reg        crc_err_r;
   reg        mps_r;
   wire       par_chk = (mr5_r[`MR5_PAR_LAT_HI:`MR5_PAR_LAT_LO] != 3'h0) &
                        (~par_err_r | mr5_r[`MR5_PERSIST]);
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         mr5_r     <= `MR5_RESET;
         mr4_r     <= `MR4_RESET;
         par_err_r <= 1'b0;
         crc_err_r <= 1'b0;
         mps_r     <= 1'b0;
         raw_q_r   <= 27'h0000000;
         cal_r     <= 4'h0;
      end
      else
      begin
         raw_q_r <= raw_cmd;
         cal_r   <= cal_nxt;
         if (wr_five)
            mr5_r <= mr_val;
         if (wr_four)
            mr4_r <= mr_val;
         // set wins over a clearing write in the same cycle
         if (par_err_event_i & par_chk)
            par_err_r <= 1'b1;
         else if (wr_five)
            par_err_r <= mr_val[`MR5_PAR_ERR];
         if (crc_err_event_i)
            crc_err_r <= 1'b1;
         else if (wr_five)
            crc_err_r <= mr_val[`MR5_CRC_ERR];
         // enter on set command, leave only on exit command
         if (max_power_exit_i)
            mps_r <= 1'b0;
         else if (wr_four)
            mps_r <= mr_val[`MR4_MAXPWR];
      end
   end
   // ------------------------------------------------------------------
   // repair bookkeeping
   // ------------------------------------------------------------------
   reg [3:0] perm_r;
   reg [3:0] tmp_r;
   wire      repair_act = cmd[26] & ~cmd[25] & ~max_power_save_o;
   wire [3:0] grp_hot = 4'h1 << cmd[21:20];
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         perm_r <= 4'h0;
         tmp_r  <= 4'h0;
      end
      else
      begin
         // one row per group, cleared only by reset
         if (repair_act & mr4_r[`MR4_PERM_REPAIR] & PERM_REPAIR_SUPPORTED)
            perm_r <= perm_r | grp_hot;
         // power-down drops temporary repairs; reset clears them too
         if (power_down_i)
            tmp_r <= 4'h0;
         else if (repair_act & mr4_r[`MR4_TMP_REPAIR] & TMP_REPAIR_SUPPORTED)
            tmp_r <= tmp_r | grp_hot;
      end
   end
   // ------------------------------------------------------------------
   // decoded outputs
   // ------------------------------------------------------------------
   reg [3:0] park_nxt;
   reg [3:0] plat_nxt;
   always @*
   begin
      case (mr5_r[`MR5_PARK_HI:`MR5_PARK_LO])
         3'h1: park_nxt = 4'h4;
         3'h2: park_nxt = 4'h2;
         3'h3: park_nxt = 4'h6;
         3'h4: park_nxt = 4'h1;
         3'h5: park_nxt = 4'h5;
         3'h6: park_nxt = 4'h3;
         3'h7: park_nxt = 4'h7;
         default: park_nxt = 4'h0;
      endcase
      case (mr5_r[`MR5_PAR_LAT_HI:`MR5_PAR_LAT_LO])
         3'h1: plat_nxt = 4'h4;
         3'h2: plat_nxt = 4'h5;
         3'h3: plat_nxt = 4'h6;
         3'h4: plat_nxt = 4'h8;
         default: plat_nxt = 4'h0;
      endcase
   end
   wire odt_ignored = power_down_i & mr5_r[`MR5_ODT_BUF_OFF];
   always @(posedge ref_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         multipurpose_readout_o    <= 8'h00;
         mode_reg_five_o           <= `MR5_RESET;
         mode_reg_four_o           <= `MR4_RESET;
         rd_bus_inversion_o        <= 1'b0;
         wr_bus_inversion_o        <= 1'b0;
         write_byte_mask_o         <= 1'b0;
         parity_latency_o          <= 4'h0;
         parked_termination_o      <= 4'h0;
         nominal_termination_o     <= 1'b0;
         parity_check_en_o         <= 1'b0;
         read_preamble_len_o       <= 2'h1;
         write_preamble_len_o      <= 2'h1;
         preamble_train_len_o      <= 2'h0;
         temp_controlled_refresh_o <= 1'b0;
         refresh_limit_c_o         <= 7'h55;
         max_power_save_o          <= 1'b0;
         cal_clocks_o              <= 4'h0;
         cmd_valid_o               <= 1'b0;
         cmd_word_o                <= 27'h0000000;
         perm_repair_used_o        <= 4'h0;
         tmp_repair_used_o         <= 4'h0;
      end
      else
      begin
         multipurpose_readout_o <= {PERM_REPAIR_SUPPORTED[0],
                                    TMP_REPAIR_SUPPORTED[0], 6'h00};
         mode_reg_five_o <= {mr5_r[21:5], par_err_r, crc_err_r, mr5_r[2:0]};
         mode_reg_four_o <= mr4_r;
         rd_bus_inversion_o <= mr5_r[`MR5_RD_INV];
         wr_bus_inversion_o <= mr5_r[`MR5_WR_INV];
         write_byte_mask_o  <= mr5_r[`MR5_WR_MASK];
         parity_latency_o   <= plat_nxt;
         parked_termination_o <= park_nxt;
         nominal_termination_o <= termination_control_i & ~odt_ignored;
         parity_check_en_o  <= par_chk;
         read_preamble_len_o  <= mr4_r[`MR4_RD_PRE] ? 2'h2 : 2'h1;
         write_preamble_len_o <= mr4_r[`MR4_WR_PRE] ? 2'h2 : 2'h1;
         // training pattern length follows the read preamble setting
         preamble_train_len_o <= mr4_r[`MR4_RD_TRAIN] ?
                                 (mr4_r[`MR4_RD_PRE] ? 2'h2 : 2'h1) : 2'h0;
         temp_controlled_refresh_o <= mr4_r[`MR4_TCR_EN];
         refresh_limit_c_o  <= mr4_r[`MR4_TCR_RANGE] ? 7'h5F : 7'h55;
         max_power_save_o   <= mps_r;
         cal_clocks_o       <= cal_r;
         // commands other than exit are dropped in max power saving
         cmd_valid_o        <= cmd[26] & ~max_power_save_o;
         cmd_word_o         <= cmd;
         perm_repair_used_o <= perm_r;
         tmp_repair_used_o  <= tmp_r;
      end
   end
endmodule
`default_nettype wire

/* dv/ddr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model (
   input  wire logic        ref_clk_i,
   output var  logic        cs_n_o,
   output var  logic [2:0]  strobe_n_o,
   output var  logic [3:0]  bank_o,
   output var  logic [17:0] addr_o
);
   initial
   begin
      cs_n_o = 1'b1;
      strobe_n_o = 3'h7;
      {bank_o, addr_o} = 22'h0;
   end
   // one set command; with latency the pins follow chip select by lat clocks
   task automatic mrs(input logic [21:0] v, input int lat);
      @(negedge ref_clk_i);
      cs_n_o = 1'b0;
      if (lat > 0)
      begin
         @(negedge ref_clk_i);
         cs_n_o = 1'b1;
         repeat (lat - 1) @(negedge ref_clk_i);
      end
      strobe_n_o = 3'h0;
      {bank_o, addr_o} = {v[21:17], 3'h0, v[13:0]};
      @(negedge ref_clk_i);
      cs_n_o = 1'b1;
      strobe_n_o = 3'h7;
      {bank_o, addr_o} = ~{bank_o, addr_o};
   endtask
endmodule
`default_nettype wire

/* dv/sdram_mode_feature_props.sv */
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_feature_props #(
   parameter logic PERM_REPAIR_SUPPORTED = 1'b1,
   parameter logic TMP_REPAIR_SUPPORTED  = 1'b1
)(
   input wire logic        ref_clk_i,
   input wire logic        reset_n_i,
   input wire logic        cs_n_i,
   input wire logic        act_n_i,
   input wire logic        ras_n_i,
   input wire logic        cas_n_i,
   input wire logic        we_n_i,
   input wire logic [1:0]  bank_group_i,
   input wire logic [1:0]  bank_i,
   input wire logic [17:0] addr_i,
   input wire logic        par_err_event_i,
   input wire logic [7:0]  multipurpose_readout_o,
   input wire logic [21:0] mode_reg_five_o,
   input wire logic        rd_bus_inversion_o,
   input wire logic        wr_bus_inversion_o,
   input wire logic        write_byte_mask_o,
   input wire logic [3:0]  parity_latency_o,
   input wire logic [3:0]  parked_termination_o,
   input wire logic        parity_check_en_o,
   input wire logic        max_power_save_o,
   input wire logic [3:0]  cal_clocks_o
);
   wire logic mrs5_w = !cs_n_i && act_n_i && !ras_n_i && !cas_n_i && !we_n_i
      && {bank_group_i[0], bank_i} == 3'h5 && cal_clocks_o == 4'h0 && !max_power_save_o;
   wire logic clr_par_w = mrs5_w && !addr_i[4];
   wire logic clr_crc_w = mrs5_w && !addr_i[3];
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_mrs5;
      mrs5_w;
   endsequence
   sequence s_stop;
      mode_reg_five_o[4] && !mode_reg_five_o[9] && parity_latency_o != 4'h0;
   endsequence
   a_mpr_bits:
      assert property (reset_n_i && $past(reset_n_i) |-> multipurpose_readout_o[7:6]
         == {PERM_REPAIR_SUPPORTED, TMP_REPAIR_SUPPORTED}) else $error("readout bits wrong");
   a_mr5_write:
      assert property (s_mrs5 |-> ##3 mode_reg_five_o[12:5] == $past(addr_i[12:5], 3))
         else $error("fifth register not written");
   a_inv_bits:
      assert property ({rd_bus_inversion_o, wr_bus_inversion_o, write_byte_mask_o}
         == mode_reg_five_o[12:10]) else $error("inversion or mask wrong");
   a_park_map:
      assert property (parked_termination_o == 4'(32'h7351_6240 >> {mode_reg_five_o[8:6], 2'h0}))
         else $error("parked termination wrong");
   a_par_latency:
      assert property (mode_reg_five_o[2:0] <= 3'h4 |-> parity_latency_o
         == 4'(20'h8_6540 >> {mode_reg_five_o[2:0], 2'h0})) else $error("parity latency wrong");
   a_par_sticky:
      assert property ($fell(mode_reg_five_o[4]) |-> $past(clr_par_w, 3))
         else $error("parity error flag dropped");
   a_crc_sticky:
      assert property ($fell(mode_reg_five_o[3]) |-> $past(clr_crc_w, 3))
         else $error("checksum error flag dropped");
   a_par_set:
      assert property (par_err_event_i && parity_check_en_o |-> ##[1:3] mode_reg_five_o[4])
         else $error("parity error flag not set");
   a_check_stop:
      assert property (s_stop [*3] |-> !parity_check_en_o) else $error("parity check not stopped");
endmodule
bind sdram_mode_feature_regs sdram_mode_feature_props #(
   .PERM_REPAIR_SUPPORTED(PERM_REPAIR_SUPPORTED),
   .TMP_REPAIR_SUPPORTED(TMP_REPAIR_SUPPORTED)
) props_i (.*);
`default_nettype wire

/* dv/test_sdram_mode_feature_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sdram_mode_feature_regs;
   logic        ref_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        par_ev = 1'b0, crc_ev = 1'b0, pd = 1'b0, term = 1'b1, mp_exit = 1'b0;
   logic        cs_n, rd_inv, wr_inv, wmask, nom, chk_en, temp_controlled_refresh, mps;
   logic [2:0]  st_n, p;
   logic [3:0]  bk, park, plat, cal;
   logic [17:0] addr;
   logic [21:0] mr5, v;
   logic [7:0]  multipurpose_readout, r;
   logic [1:0]  rpre, wpre, train;
   logic [6:0]  rlim;
   int          fails = 0;
   int          total_checks = 0;
   ddr_ctrl_model ddr_ctrl_model_i (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .strobe_n_o(st_n),
      .bank_o(bk), .addr_o(addr));
   sdram_mode_feature_regs sdram_mode_feature_regs_i (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .cs_n_i(cs_n), .act_n_i(1'b1), .ras_n_i(st_n[2]),
      .cas_n_i(st_n[1]), .we_n_i(st_n[0]), .bank_group_i(bk[3:2]), .bank_i(bk[1:0]),
      .addr_i(addr), .par_err_event_i(par_ev), .crc_err_event_i(crc_ev), .power_down_i(pd),
      .termination_control_i(term), .max_power_exit_i(mp_exit), .multipurpose_readout_o(multipurpose_readout),
      .mode_reg_five_o(mr5), .mode_reg_four_o(), .rd_bus_inversion_o(rd_inv),
      .wr_bus_inversion_o(wr_inv), .write_byte_mask_o(wmask), .parity_latency_o(plat),
      .parked_termination_o(park), .nominal_termination_o(nom), .parity_check_en_o(chk_en),
      .read_preamble_len_o(rpre), .write_preamble_len_o(wpre), .preamble_train_len_o(train),
      .temp_controlled_refresh_o(temp_controlled_refresh), .refresh_limit_c_o(rlim), .max_power_save_o(mps),
      .cal_clocks_o(cal), .cmd_valid_o(), .cmd_word_o(), .perm_repair_used_o(),
      .tmp_repair_used_o());
   initial
   begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [21:0] x, input int lat);
      ddr_ctrl_model_i.mrs(x, lat);
      repeat (4) @(negedge ref_clk_i);
   endtask
   task automatic pulse(input int which);
      @(negedge ref_clk_i);
      {par_ev, crc_ev, mp_exit} = 3'(which);
      @(negedge ref_clk_i);
      {par_ev, crc_ev, mp_exit} = 3'h0;
      repeat (4) @(negedge ref_clk_i);
   endtask
   function automatic logic [3:0] nib(input logic [31:0] t, input logic [2:0] c);
      return 4'(t >> {c, 2'h0});
   endfunction
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge ref_clk_i);
      fails++;
      final_report();
   end
   initial
   begin
      void'($urandom(99247));
      repeat (20) @(negedge ref_clk_i);
      reset_n_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk("reset", mr5, 22'h0);
      chk("reset_dec", {rpre, wpre, rlim}, {4'h5, 7'h55});
      chk("readout", multipurpose_readout[7:6], 2'h3);
      for (int i = 0; i < 14; i++)
      begin
         r = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom());
         p = (i < 5) ? 3'(i) : 3'($urandom_range(4));
         v = {8'h50, 1'b0, r, 2'h0, p};
         wr(v, 0);
         chk("fields", {mr5[12:5], mr5[2:0]}, {r, p});
         chk("inv", {rd_inv, wr_inv, wmask}, r[7:5]);
         chk("park", park, nib(32'h7351_6240, r[3:1]));
         chk("plat", plat, nib(20'h8_6540, p));
      end
      for (int k = 0; k < 8; k++)
      begin
         wr({8'h40, 1'b0, 3'(k), 6'h0, 1'b1, k[1], 2'h0}, 0);
         chk("wpre", wpre, k[2] ? 2'h2 : 2'h1);
         chk("rpre", rpre, k[1] ? 2'h2 : 2'h1);
         chk("train", train, k[0] ? (k[1] ? 2'h2 : 2'h1) : 2'h0);
         chk("tcr", {temp_controlled_refresh, rlim}, {1'b1, k[1] ? 7'h5F : 7'h55});
         chk("hold", {mr5[12:5], mr5[2:0]}, {v[12:5], v[2:0]});
      end
      wr({8'h50, 14'h1}, 0);
      chk("chk_on", chk_en, 1'b1);
      pulse(6);
      chk("errs", {mr5[4:3], chk_en}, 3'h6);
      wr({8'h40, 14'h0}, 0);
      chk("sticky", mr5[4:3], 2'h3);
      wr({8'h50, 14'h201}, 0);
      pulse(4);
      chk("persist", {mr5[4:3], chk_en}, 3'h5);
      wr({8'h50, 14'h20}, 0);
      pd = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      chk("nom_off", nom, 1'b0);
      pd = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      chk("nom_on", nom, 1'b1);
      wr({8'h40, 14'h2}, 0);
      chk("mps_on", mps, 1'b1);
      wr({8'h50, 14'h1FE0}, 0);
      chk("ignored", mr5[12:5], 8'h01);
      pulse(1);
      chk("mps_off", mps, 1'b0);
      for (int c = 1; c < 7; c++)
      begin
         wr({8'h40, 5'h0, 3'(c % 6), 6'h0}, int'(nib(24'h86_5430, 3'(c - 1))));
         chk("cal", cal, nib(24'h86_5430, 3'(c % 6)));
         r = 8'($urandom());
         wr({8'h50, 1'b0, r, 5'h0}, int'(cal));
         chk("cal_wr", mr5[12:5], r);
      end
      final_report();
   end
endmodule
`default_nettype wire
